// [msd_spi_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
module msd_spi_ctrl #(
  parameter int SETTLE_CYCLES = msd_pkg::CP_SETTLE_CYCLES
) (
  // Clock and reset.
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  // Serial port, mode 0.
  input wire logic SPI_CLK_IN,
  input wire logic SPI_CS_N_IN,
  input wire logic SPI_DI_IN,
  output logic SPI_DO_OUT,
  output logic SPI_DO_OE_OUT,
  // Status from the analog side.
  input wire msd_pkg::msd_status_t STATUS_IN,
  // Motion pins.
  input wire logic DIR_IN,
  input wire logic STEP_ADVANCE_PIN_IN,
  // Decoded controls.
  output logic STEP_PULSE_OUT,
  output logic ROTATE_CW_OUT,
  output logic DRIVERS_ENABLE_OUT,
  output logic SLEEP_OUT,
  output logic STEP_READY_OUT,
  output msd_pkg::msd_step_mode_t STEP_MODE_OUT,
  output logic STEP_MODE_VALID_OUT,
  output logic [4:0] COIL_AMPLITUDE_SEL_OUT,
  output msd_pkg::msd_slope_t SLOPE_SEL_OUT,
  output logic PWM_DOUBLE_OUT,
  output logic PWM_JITTER_OUT,
  output logic LA_GAIN_QUARTER_OUT,
  output logic LA_TRANSPARENT_OUT
);
  import msd_pkg::*;

  localparam int CW = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CW-1:0] SETTLE_LOAD = CW'(SETTLE_CYCLES);

  generate
    if (SETTLE_CYCLES < 1) begin : g_bad_settle
      $error("SETTLE_CYCLES must be at least one");
    end
  endgenerate

  // Serial state.
  logic sclk_q, next_sclk_q;
  logic cs_n_q, next_cs_n_q;
  logic [2:0] bit_idx, next_bit_idx;
  logic load_due, next_load_due;
  logic [7:0] rx_shift, next_rx_shift;
  logic [7:0] tx_shift, next_tx_shift;
  msd_phase_t phase, next_phase;
  logic [4:0] addr, next_addr;
  logic wr_track, next_wr_track;
  logic [4:0] wr_bits, next_wr_bits;
  logic [7:0] wr_data, next_wr_data;
  logic do_q, next_do_q;
  logic do_oe, next_do_oe;

  // Register file and snapshot.
  msd_step_cfg_t step_current_config, next_step_current_config;
  msd_drive_cfg_t drive_option_config, next_drive_option_config;
  msd_power_cfg_t power_loadangle_config, next_power_loadangle_config;
  msd_status_t status_snap, next_status_snap;

  // Motion state.
  logic step_q, next_step_q;
  logic [CW-1:0] settle_cnt, next_settle_cnt;
  logic step_pulse, next_step_pulse;
  logic rotate_cw, next_rotate_cw;
  logic step_ready, next_step_ready;
  logic mode_valid, next_mode_valid;
  // Settle start is a one-cycle strobe from the commit logic to the motion group.
  logic settle_start;

  function automatic logic [7:0] read_reg(input logic [4:0] a, input msd_step_cfg_t c0,
                                          input msd_drive_cfg_t c1, input msd_power_cfg_t c2,
                                          input msd_status_t st);
    logic [7:0] v;
    v = UNMAPPED_READ;
    case (a)
      ADDR_STEP_CURRENT: v = c0;
      ADDR_DRIVE_OPTION: v = {c1.dir_invert, c1.step_on_falling, 2'b00, c1.pwm_double, c1.pwm_jitter, c1.slope_sel};
      ADDR_POWER_LOADANGLE: v = {c2.drive_enable, c2.sleep, c2.la_gain_quarter, c2.la_transparent, 4'h0};
      ADDR_STATUS0: v = st.status0;
      ADDR_STATUS1: v = st.status1;
      ADDR_STATUS2: v = st.status2;
      ADDR_STATUS3: v = st.status3;
      default: v = UNMAPPED_READ;
    endcase
    return v;
  endfunction : read_reg

  logic sclk_rise, sclk_fall, cs_rise, selected, step_edge;
  logic [7:0] rx_byte;

  always_comb begin
    selected = !SPI_CS_N_IN;
    sclk_rise = selected && SPI_CLK_IN && !sclk_q;
    sclk_fall = selected && !SPI_CLK_IN && sclk_q;
    cs_rise = SPI_CS_N_IN && !cs_n_q;
    rx_byte = {rx_shift[6:0], SPI_DI_IN};

    next_sclk_q = SPI_CLK_IN;
    next_cs_n_q = SPI_CS_N_IN;
    next_bit_idx = bit_idx;
    next_load_due = load_due;
    next_rx_shift = rx_shift;
    next_tx_shift = tx_shift;
    next_phase = phase;
    next_addr = addr;
    next_wr_track = wr_track;
    next_wr_bits = wr_bits;
    next_wr_data = wr_data;
    next_step_current_config = step_current_config;
    next_drive_option_config = drive_option_config;
    next_power_loadangle_config = power_loadangle_config;
    next_status_snap = status_snap;
    settle_start = 1'b0;

    if (sclk_rise) begin
      next_rx_shift = rx_byte;
      next_bit_idx = bit_idx + 3'd1;
      if (wr_track && wr_bits != BIT_COUNT_MAX) begin
        next_wr_bits = wr_bits + 5'd1;
      end
      if (bit_idx == LAST_BIT_OF_BYTE) begin
        next_load_due = 1'b1;
        if (phase == PH_DATA) begin
          next_wr_data = rx_byte;
          next_phase = PH_CMD;
        end else if (rx_byte[7:CMD_POS] == CMD_WRITE) begin
          next_addr = rx_byte[4:0];
          next_phase = PH_DATA;
          next_wr_track = 1'b1;
          next_wr_bits = CMD_BYTE_BITS;
        end else if (rx_byte[7:CMD_POS] == CMD_READ) begin
          next_addr = rx_byte[4:0];
        end
      end
    end

    if (sclk_fall) begin
      if (load_due) begin
        // Loading only here means the old value of a just-written register goes out first.
        next_tx_shift = read_reg(addr, step_current_config, drive_option_config,
                                 power_loadangle_config, status_snap);
        next_load_due = 1'b0;
      end else begin
        next_tx_shift = {tx_shift[6:0], 1'b0};
      end
    end

    if (SPI_CS_N_IN) begin
      next_status_snap = STATUS_IN;
      next_bit_idx = 3'd0;
      next_load_due = 1'b0;
      next_phase = PH_CMD;
      next_wr_track = 1'b0;
      next_wr_bits = 5'd0;
    end

    // A packet cut short or overrun must not land, so a write commits only when exactly sixteen bits follow from the start of its command byte.
    if (cs_rise && wr_track && wr_bits == WRITE_PACKET_BITS && bit_idx == 3'd0) begin
      case (addr)
        ADDR_STEP_CURRENT: next_step_current_config = wr_data;
        ADDR_DRIVE_OPTION: begin
          next_drive_option_config = wr_data;
          next_drive_option_config.unused = 2'b00;
        end
        ADDR_POWER_LOADANGLE: begin
          next_power_loadangle_config = wr_data;
          next_power_loadangle_config.unused = 4'h0;
          if (power_loadangle_config.sleep && !wr_data[6]) begin
            settle_start = 1'b1;
          end
        end
        default: next_step_current_config = step_current_config;
      endcase
    end
    next_mode_valid = (next_step_current_config.step_resolution_sel != SM_UNUSED);

    // Nothing is driven while deselected; the board's pull-up then holds the line high.
    next_do_q = next_tx_shift[7];
    next_do_oe = !SPI_CS_N_IN;
  end

  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      bit_idx <= 3'd0;
      load_due <= 1'b0;
      rx_shift <= CFG_RESET;
      tx_shift <= CFG_RESET;
      phase <= PH_CMD;
      addr <= 5'h00;
      wr_track <= 1'b0;
      wr_bits <= 5'd0;
      wr_data <= CFG_RESET;
      do_q <= 1'b0;
      do_oe <= 1'b0;
      step_current_config <= CFG_RESET;
      drive_option_config <= CFG_RESET;
      power_loadangle_config <= CFG_RESET;
      status_snap <= {4{STATUS_RESET}};
      mode_valid <= 1'b1;
    end else begin
      sclk_q <= next_sclk_q;
      cs_n_q <= next_cs_n_q;
      bit_idx <= next_bit_idx;
      load_due <= next_load_due;
      rx_shift <= next_rx_shift;
      tx_shift <= next_tx_shift;
      phase <= next_phase;
      addr <= next_addr;
      wr_track <= next_wr_track;
      wr_bits <= next_wr_bits;
      wr_data <= next_wr_data;
      do_q <= next_do_q;
      do_oe <= next_do_oe;
      step_current_config <= next_step_current_config;
      drive_option_config <= next_drive_option_config;
      power_loadangle_config <= next_power_loadangle_config;
      status_snap <= next_status_snap;
      mode_valid <= next_mode_valid;
    end
  end

  // Step pin, direction and charge pump settling.
  always_comb begin
    step_edge = drive_option_config.step_on_falling ? (step_q && !STEP_ADVANCE_PIN_IN)
                                                    : (!step_q && STEP_ADVANCE_PIN_IN);
    next_settle_cnt = (settle_cnt != '0) ? settle_cnt - CW'(1) : settle_cnt;
    if (settle_start) begin
      next_settle_cnt = SETTLE_LOAD;
    end
    next_step_ready = (next_settle_cnt == '0);
    next_step_q = STEP_ADVANCE_PIN_IN;
    // Stepping before the pump has settled would drive the coils from a weak gate supply.
    next_step_pulse = step_edge && !power_loadangle_config.sleep && step_ready;
    // In sleep the direction pin is ignored, so the last direction is held.
    next_rotate_cw = power_loadangle_config.sleep ? rotate_cw
                                                  : (DIR_IN == drive_option_config.dir_invert);
  end

  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      step_q <= 1'b0;
      settle_cnt <= '0;
      step_ready <= 1'b1;
      step_pulse <= 1'b0;
      rotate_cw <= 1'b0;
    end else begin
      step_q <= next_step_q;
      settle_cnt <= next_settle_cnt;
      step_ready <= next_step_ready;
      step_pulse <= next_step_pulse;
      rotate_cw <= next_rotate_cw;
    end
  end

  // Decoded controls are register bits or registered step, direction, ready and mode-valid state, so they come straight from flip-flops.
  always_comb begin
    SPI_DO_OUT = do_q;
    SPI_DO_OE_OUT = do_oe;
    STEP_PULSE_OUT = step_pulse;
    ROTATE_CW_OUT = rotate_cw;
    STEP_READY_OUT = step_ready;
    SLEEP_OUT = power_loadangle_config.sleep;
    DRIVERS_ENABLE_OUT = power_loadangle_config.drive_enable;
    STEP_MODE_OUT = step_current_config.step_resolution_sel;
    STEP_MODE_VALID_OUT = mode_valid;
    COIL_AMPLITUDE_SEL_OUT = step_current_config.coil_amplitude_sel;
    SLOPE_SEL_OUT = drive_option_config.slope_sel;
    PWM_DOUBLE_OUT = drive_option_config.pwm_double;
    PWM_JITTER_OUT = drive_option_config.pwm_jitter;
    LA_GAIN_QUARTER_OUT = power_loadangle_config.la_gain_quarter;
    LA_TRANSPARENT_OUT = power_loadangle_config.la_transparent;
  end

endmodule : msd_spi_ctrl
`default_nettype wire

// [msd_pkg.sv]
`default_nettype none
package msd_pkg;

  // Register map of the serial port.
  localparam logic [4:0] ADDR_STEP_CURRENT = 5'h01;
  localparam logic [4:0] ADDR_DRIVE_OPTION = 5'h02;
  localparam logic [4:0] ADDR_POWER_LOADANGLE = 5'h03;
  localparam logic [4:0] ADDR_STATUS0 = 5'h04;
  localparam logic [4:0] ADDR_STATUS1 = 5'h05;
  localparam logic [4:0] ADDR_STATUS2 = 5'h06;
  localparam logic [4:0] ADDR_STATUS3 = 5'h07;

  // Command field, top three bits of the first byte.
  localparam logic [2:0] CMD_READ = 3'h0;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam int CMD_POS = 5;

  // Framing.
  localparam logic [2:0] LAST_BIT_OF_BYTE = 3'h7;
  localparam logic [4:0] CMD_BYTE_BITS = 5'h08;
  localparam logic [4:0] WRITE_PACKET_BITS = 5'h10;
  localparam logic [4:0] BIT_COUNT_MAX = 5'h1f;

  // Reset values.
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Charge pump settling after leaving sleep.
  localparam int REF_CLK_MHZ = 20;
  localparam int CP_SETTLE_US = 1000;
  localparam int CP_SETTLE_CYCLES = (CP_SETTLE_US * REF_CLK_MHZ < 1) ? 1 : CP_SETTLE_US * REF_CLK_MHZ;

  typedef enum logic [2:0] {
    SM_MICRO32 = 3'b000,
    SM_MICRO16 = 3'b001,
    SM_MICRO8 = 3'b010,
    SM_MICRO4 = 3'b011,
    SM_HALF_COMP = 3'b100,
    SM_HALF_UNCOMP = 3'b101,
    SM_FULL = 3'b110,
    SM_UNUSED = 3'b111
  } msd_step_mode_t;

  typedef enum logic [1:0] {
    SLOPE_VERY_FAST = 2'b00,
    SLOPE_FAST = 2'b01,
    SLOPE_SLOW = 2'b10,
    SLOPE_VERY_SLOW = 2'b11
  } msd_slope_t;

  typedef enum logic [1:0] {
    PH_CMD = 2'b00,
    PH_DATA = 2'b01
  } msd_phase_t;

  typedef struct packed {
    msd_step_mode_t step_resolution_sel;
    logic [4:0] coil_amplitude_sel;
  } msd_step_cfg_t;

  typedef struct packed {
    logic dir_invert;
    logic step_on_falling;
    logic [1:0] unused;
    logic pwm_double;
    logic pwm_jitter;
    msd_slope_t slope_sel;
  } msd_drive_cfg_t;

  typedef struct packed {
    logic drive_enable;
    logic sleep;
    logic la_gain_quarter;
    logic la_transparent;
    logic [3:0] unused;
  } msd_power_cfg_t;

  typedef struct packed {
    logic [7:0] status3;
    logic [7:0] status2;
    logic [7:0] status1;
    logic [7:0] status0;
  } msd_status_t;

endpackage : msd_pkg
`default_nettype wire

// [msd_spi_master.sv]
`timescale 1ns/1ns
`default_nettype none
module msd_spi_master (
  // System clock.
  input wire logic clk_in,
  // Serial lines.
  output logic sclk_out,
  output logic cs_n_out,
  output logic di_out,
  input wire logic do_in,
  input wire logic oe_in
);
  logic do_w;
  // The data-out line has a pull-up, so a released line reads high.
  assign do_w = oe_in ? do_in : 1'b1;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    di_out = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_in);
  endtask : wait_n
  // Each clock phase spans three system cycles, since the slave samples the serial clock.
  task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
    rx = 32'h0000_0000;
    cs_n_out = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      di_out = tx[i];
      wait_n(3);
      sclk_out = 1'b1;
      rx[i] = do_w;
      wait_n(3);
      sclk_out = 1'b0;
    end
    wait_n(3);
    cs_n_out = 1'b1;
    wait_n(3);
  endtask : xfer
endmodule : msd_spi_master
`default_nettype wire

// [msd_spi_ctrl_props.sv]
`timescale 1ns/1ns
`default_nettype none
module msd_spi_ctrl_props #(
  parameter int SETTLE_CYCLES = 8
) (
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic SPI_CLK_IN,
  input wire logic SPI_CS_N_IN,
  input wire logic SPI_DO_OUT,
  input wire logic SPI_DO_OE_OUT,
  input wire logic STEP_ADVANCE_PIN_IN,
  input wire logic STEP_PULSE_OUT,
  input wire logic DRIVERS_ENABLE_OUT,
  input wire logic SLEEP_OUT,
  input wire logic STEP_READY_OUT,
  input wire msd_pkg::msd_step_mode_t STEP_MODE_OUT,
  input wire logic STEP_MODE_VALID_OUT,
  input wire logic [4:0] COIL_AMPLITUDE_SEL_OUT,
  input wire msd_pkg::msd_slope_t SLOPE_SEL_OUT,
  input wire logic PWM_DOUBLE_OUT,
  input wire logic PWM_JITTER_OUT,
  input wire logic LA_GAIN_QUARTER_OUT,
  input wire logic LA_TRANSPARENT_OUT
);
  import msd_pkg::*;
  localparam int SETTLE_MAX = SETTLE_CYCLES + 3;
  logic [15:0] cfg;
  assign cfg = {STEP_MODE_OUT, COIL_AMPLITUDE_SEL_OUT, SLOPE_SEL_OUT, PWM_DOUBLE_OUT, PWM_JITTER_OUT,
    LA_GAIN_QUARTER_OUT, LA_TRANSPARENT_OUT, DRIVERS_ENABLE_OUT, SLEEP_OUT};
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  a_oe_tracks_cs: assert property (SPI_DO_OE_OUT == !$past(SPI_CS_N_IN))
    else $error("output enable does not follow chip select");
  a_cfg_cs_high: assert property ($changed(cfg) |-> SPI_CS_N_IN && $past(SPI_CS_N_IN))
    else $error("control output changed while selected");
  a_mode_valid: assert property (STEP_MODE_VALID_OUT == (STEP_MODE_OUT != SM_UNUSED))
    else $error("step mode valid flag wrong");
  a_pulse_cause: assert property (STEP_PULSE_OUT |-> ($past(STEP_ADVANCE_PIN_IN) != $past(STEP_ADVANCE_PIN_IN, 2))
    || ($past(STEP_ADVANCE_PIN_IN, 2) != $past(STEP_ADVANCE_PIN_IN, 3)))
    else $error("step pulse without pin edge");
  a_pulse_single: assert property (STEP_PULSE_OUT |=> !STEP_PULSE_OUT)
    else $error("step pulse longer than one cycle");
  a_pulse_gated: assert property (STEP_PULSE_OUT |-> $past(STEP_READY_OUT) && !$past(SLEEP_OUT))
    else $error("step pulse in sleep or settle");
  a_settle_start: assert property ($fell(SLEEP_OUT) |-> ##[0:2] !STEP_READY_OUT)
    else $error("no settle after wake");
  a_settle_end: assert property ($fell(STEP_READY_OUT) |-> ##[1:SETTLE_MAX] STEP_READY_OUT)
    else $error("settle too long");
  a_do_on_fall: assert property ($changed(SPI_DO_OUT) && !SPI_CS_N_IN && !$past(SPI_CS_N_IN, 2)
    |-> !$past(SPI_CLK_IN) && $past(SPI_CLK_IN, 2))
    else $error("data out moved without serial clock fall");
  c_settle: cover property ($fell(STEP_READY_OUT));
  c_pulse: cover property (STEP_PULSE_OUT);
  c_commit: cover property ($changed(cfg));
  c_mode_bad: cover property (!STEP_MODE_VALID_OUT);
endmodule : msd_spi_ctrl_props
bind msd_spi_ctrl msd_spi_ctrl_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_props (.REF_CLK_IN(REF_CLK_IN),
  .RSTN_IN(RSTN_IN), .SPI_CLK_IN(SPI_CLK_IN), .SPI_CS_N_IN(SPI_CS_N_IN), .SPI_DO_OUT(SPI_DO_OUT),
  .SPI_DO_OE_OUT(SPI_DO_OE_OUT), .STEP_ADVANCE_PIN_IN(STEP_ADVANCE_PIN_IN), .STEP_PULSE_OUT(STEP_PULSE_OUT),
  .DRIVERS_ENABLE_OUT(DRIVERS_ENABLE_OUT), .SLEEP_OUT(SLEEP_OUT), .STEP_READY_OUT(STEP_READY_OUT),
  .STEP_MODE_OUT(STEP_MODE_OUT), .STEP_MODE_VALID_OUT(STEP_MODE_VALID_OUT),
  .COIL_AMPLITUDE_SEL_OUT(COIL_AMPLITUDE_SEL_OUT), .SLOPE_SEL_OUT(SLOPE_SEL_OUT),
  .PWM_DOUBLE_OUT(PWM_DOUBLE_OUT), .PWM_JITTER_OUT(PWM_JITTER_OUT),
  .LA_GAIN_QUARTER_OUT(LA_GAIN_QUARTER_OUT), .LA_TRANSPARENT_OUT(LA_TRANSPARENT_OUT));
`default_nettype wire

// [msd_spi_ctrl_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module msd_spi_ctrl_tb_top;
  import msd_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic dir = 1'b0;
  logic pin = 1'b0;
  logic sclk, cs_n, di, dout, oe, pulse, cw, drv, slp, rdy, mvalid, pdbl, pjit, lag, lat, prev;
  logic [4:0] amp;
  msd_step_mode_t mode;
  msd_slope_t slope;
  msd_status_t status = 32'h0000_0000;
  logic [31:0] rx, st, cnt;
  logic [7:0] shadow [1:3];
  int bad_count = 0;
  int n_checks = 0;
  always #25 clk = ~clk;
  msd_spi_master u_mst (.clk_in(clk), .sclk_out(sclk), .cs_n_out(cs_n), .di_out(di), .do_in(dout), .oe_in(oe));
  msd_spi_ctrl #(.SETTLE_CYCLES(8)) u_dut (.REF_CLK_IN(clk), .RSTN_IN(rstn), .SPI_CLK_IN(sclk), .SPI_CS_N_IN(cs_n),
    .SPI_DI_IN(di), .SPI_DO_OUT(dout), .SPI_DO_OE_OUT(oe), .STATUS_IN(status), .DIR_IN(dir),
    .STEP_ADVANCE_PIN_IN(pin), .STEP_PULSE_OUT(pulse), .ROTATE_CW_OUT(cw), .DRIVERS_ENABLE_OUT(drv),
    .SLEEP_OUT(slp), .STEP_READY_OUT(rdy), .STEP_MODE_OUT(mode), .STEP_MODE_VALID_OUT(mvalid),
    .COIL_AMPLITUDE_SEL_OUT(amp), .SLOPE_SEL_OUT(slope), .PWM_DOUBLE_OUT(pdbl), .PWM_JITTER_OUT(pjit),
    .LA_GAIN_QUARTER_OUT(lag), .LA_TRANSPARENT_OUT(lat));
  // Reserved bits are not stored and read back as zero.
  function automatic logic [7:0] rmask(input int a);
    return (a == 1) ? 8'hff : (a == 2) ? 8'hcf : 8'hf0;
  endfunction : rmask
  function automatic logic [7:0] vexp(input int a, input logic [7:0] v);
    return v & rmask(a) & ((a == 2) ? 8'h0f : 8'hff);
  endfunction : vexp
  function automatic logic [7:0] view(input int a);
    return (a == 1) ? {mode, amp} : (a == 2) ? {4'h0, pdbl, pjit, slope} : {drv, slp, lag, lat, 4'h0};
  endfunction : view
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  // A read in a fresh packet first returns the value loaded before the commit.
  task automatic wr(input int a, input logic [7:0] v);
    u_mst.xfer({16'h0000, CMD_WRITE, 5'(a), v}, 16, rx);
    chk(rx[7:0], shadow[a]);
    chk(view(a), vexp(a, v));
    if (a == 1) begin
      chk(mvalid, v[7:5] != 3'h7);
    end
    u_mst.xfer({16'h0000, CMD_READ, 5'(a), 8'h00}, 16, rx);
    chk(rx[15:8], shadow[a]);
    shadow[a] = v & rmask(a);
    chk(rx[7:0], shadow[a]);
  endtask : wr
  initial begin
    void'($urandom(77327));
    for (int a = 1; a <= 3; a++) shadow[a] = CFG_RESET;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    for (int a = 1; a <= 3; a++) begin
      u_mst.xfer({16'h0000, CMD_READ, 5'(a), 8'h00}, 16, rx);
      chk(rx[7:0], CFG_RESET);
    end
    for (int k = 0; k < 15; k++) wr(k % 3 + 1, (k < 3) ? 8'hff : (k > 11) ? 8'h00 : 8'($urandom));
    u_mst.xfer({17'h0_0000, CMD_WRITE, ADDR_STEP_CURRENT, 7'h2a}, 15, rx);
    u_mst.xfer({15'h0000, CMD_WRITE, ADDR_STEP_CURRENT, 9'h0b5}, 17, rx);
    chk(view(1), shadow[1]);
    status = $urandom;
    st = status;
    @(negedge clk);
    fork
      u_mst.xfer({CMD_READ, ADDR_STATUS0, CMD_READ, ADDR_STATUS1, CMD_WRITE, ADDR_DRIVE_OPTION, 8'h3d}, 32, rx);
      begin
        repeat (20) @(negedge clk);
        status = ~st;
      end
    join
    chk(rx[23:8], {st[7:0], st[15:8]});
    chk(rx[7:0], shadow[2]);
    shadow[2] = 8'h3d & rmask(2);
    chk(view(2), vexp(2, 8'h3d));
    wr(3, 8'h40);
    chk(rdy, 1'b1);
    u_mst.xfer({16'h0000, CMD_WRITE, ADDR_POWER_LOADANGLE, 8'h80}, 16, rx);
    chk(rx[7:0], shadow[3]);
    shadow[3] = 8'h80;
    chk(rdy, 1'b0);
    repeat (10) @(negedge clk);
    chk(rdy, 1'b1);
    for (int p = 0; p < 2; p++) begin
      wr(2, p ? 8'hc0 : 8'h00);
      for (int j = 0; j < 24; j++) begin
        prev = pin;
        pin = 1'($urandom);
        dir = 1'($urandom);
        cnt = 32'h0000_0000;
        repeat (3) begin
          @(negedge clk);
          cnt = cnt + pulse;
        end
        chk(cnt, p ? (prev & ~pin) : (~prev & pin));
        chk(cw, dir == p[0]);
      end
    end
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
endmodule : msd_spi_ctrl_tb_top
`default_nettype wire
